// >>> common/aer_consts.svh
`ifndef AER_CONSTS_SVH
`define AER_CONSTS_SVH

// register offsets (byte addresses)
`define AER_OFF_SEVERITY    12'h10c
`define AER_OFF_CORR_STATUS 12'h110
`define AER_OFF_UNCORR_MASK 12'h108
`define AER_OFF_CORR_MASK   12'h114

// severity field positions
`define AER_SEV_UNUSED_BIT   0
`define AER_SEV_LINK_PROT    4
`define AER_SEV_SURPRISE     5
`define AER_SEV_POISONED     12
`define AER_SEV_FLOW_PROT    13
`define AER_SEV_COMPL_TO     14
`define AER_SEV_COMPL_ABORT  15
`define AER_SEV_UNEXP_COMPL  16
`define AER_SEV_RX_OVERFLOW  17
`define AER_SEV_BAD_FORMAT   18
`define AER_SEV_ECRC         19
`define AER_SEV_UNSUP_REQ    20

// correctable status field positions
`define AER_COR_RX_ERR       0
`define AER_COR_BAD_TLP      6
`define AER_COR_BAD_DLLP     7
`define AER_COR_REPLAY_ROLL  8
`define AER_COR_REPLAY_TMO   12
`define AER_COR_ADVISORY     13

// writable masks and reset values
`define AER_SEV_WR_MASK      32'h001f3031
`define AER_SEV_RESET        32'h00062030
`define AER_COR_WR_MASK      32'h000031c1
`define AER_COR_RESET        32'h00000000
`define AER_UMASK_WR_MASK    32'h001f3031
`define AER_UMASK_RESET      32'h00000000
`define AER_CMASK_RESET      32'h00002000

`endif

// >>> common/aer_pkg.sv
package aer_pkg;
  typedef logic [31:0] aer_word_t;
  typedef logic [11:0] aer_addr_t;
  typedef enum logic [1:0] {AER_NONE, AER_NONFATAL, AER_FATAL} aer_sev_e;
endpackage : aer_pkg

// >>> core/aer_regs.sv
// Chosen here: the strobed register port.
`include "aer_consts.svh"
// ****************************************************************
// Contract
// - unmasked uncorrectable event on a writable bit other than 0 reports fatal if severity bit set, else non-fatal
// - severity applies only to unmasked events; masked events not reported at all
// - severity bit 0 writable sticky unused, resets zero, no effect
// - severity bit 4 link protocol error rw sticky, resets one
// - severity bit 5 surprise down rw sticky, resets one
// - severity bit 12 poisoned tlp rw sticky, resets zero
// - severity bit 13 flow control protocol error rw sticky, resets one
// - severity bit 14 completion timeout read-only zero
// - severity bit 15 completer abort read-only zero
// - severity bit 16 unexpected completion rw sticky, resets zero
// - severity bit 17 receiver overflow rw sticky, resets one
// - severity bit 18 bad format tlp rw sticky, resets one
// - severity bit 19 ecrc rw sticky, resets zero
// - severity bit 20 unsupported request rw sticky, resets zero
// - correctable bit 0 set on receiver error, sticky, write one clears
// - correctable bit 6 set on corrupt tlp, sticky, write one clears
// - correctable bit 7 set on corrupt dllp, sticky, write one clears
// - correctable bit 8 set on replay count rollover, write one clears
// - correctable bit 12 set on replay timer expiry, sticky, write one clears
// - correctable bit 13 set on advisory nonfatal, sticky, write one clears
// - masked correctable events still set status but are not reported
// ****************************************************************
module aer_regs (
  input  wire logic               CLK_I,
  input  wire logic               RESET_N_I,
  input  wire logic               HOT_RESET_I,
  input  wire logic               CE_I,
  input  wire aer_pkg::aer_addr_t ADDR_I,
  input  wire aer_pkg::aer_word_t WDATA_I,
  input  wire logic               WR_I,
  input  wire logic               RD_I,
  output aer_pkg::aer_word_t      RDATA_O,
  input  wire logic [31:0]        UNCORR_EVENT_I,
  input  wire logic [31:0]        CORR_EVENT_I,
  output logic                    FATAL_REPORT_O,
  output logic                    NONFATAL_REPORT_O,
  output logic                    CORR_REPORT_O
);

  // ****************************************************************
  // decode
  // ****************************************************************
  aer_pkg::aer_word_t uncorr_severity_reg;
  aer_pkg::aer_word_t corr_status_reg;
  aer_pkg::aer_word_t uncorr_mask_reg;
  aer_pkg::aer_word_t corr_mask_reg;
  aer_pkg::aer_word_t rdata;
  logic               fatal_q;
  logic               nonfatal_q;
  logic               corr_q;

  // one compare serves the write strobes and the read mux alike, so the two
  // decodes can never drift apart when an offset moves
  function automatic logic hit(input aer_pkg::aer_addr_t a, input aer_pkg::aer_addr_t off);
    hit = (a == off);
  endfunction : hit

  // every strobe is gated by the clock enable, so a frozen block takes no write
  wire logic wr_sev   = CE_I && WR_I && hit(ADDR_I, `AER_OFF_SEVERITY);
  wire logic wr_cor   = CE_I && WR_I && hit(ADDR_I, `AER_OFF_CORR_STATUS);
  wire logic wr_umask = CE_I && WR_I && hit(ADDR_I, `AER_OFF_UNCORR_MASK);
  wire logic wr_cmask = CE_I && WR_I && hit(ADDR_I, `AER_OFF_CORR_MASK);

  // read mux; unmapped offsets read zero
  aer_pkg::aer_word_t rd_mux;
  always_comb
  begin
    if (hit(ADDR_I, `AER_OFF_SEVERITY))
      rd_mux = uncorr_severity_reg;
    else if (hit(ADDR_I, `AER_OFF_CORR_STATUS))
      rd_mux = corr_status_reg;
    else if (hit(ADDR_I, `AER_OFF_UNCORR_MASK))
      rd_mux = uncorr_mask_reg;
    else if (hit(ADDR_I, `AER_OFF_CORR_MASK))
      rd_mux = corr_mask_reg;
    else
      rd_mux = 32'h00000000;
  end

  // ****************************************************************
  // sticky registers
  // ****************************************************************
  // only the async reset (fundamental) restores defaults; hot reset is ignored on purpose
  wire aer_pkg::aer_word_t cor_evt = CORR_EVENT_I & `AER_COR_WR_MASK;
  // set wins over a simultaneous write-one clear
  wire aer_pkg::aer_word_t next_cor = (corr_status_reg & ~(wr_cor ? WDATA_I : 32'h00000000)) | cor_evt;

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      uncorr_severity_reg <= `AER_SEV_RESET;
      corr_status_reg     <= `AER_COR_RESET;
      uncorr_mask_reg     <= `AER_UMASK_RESET;
      corr_mask_reg       <= `AER_CMASK_RESET;
    end
    else if (CE_I)
    begin
      if (wr_sev)
        uncorr_severity_reg <= WDATA_I & `AER_SEV_WR_MASK;
      if (wr_umask)
        uncorr_mask_reg <= WDATA_I & `AER_UMASK_WR_MASK;
      if (wr_cmask)
        corr_mask_reg <= WDATA_I & `AER_COR_WR_MASK;
      corr_status_reg <= next_cor & `AER_COR_WR_MASK;
    end
  end

  // ****************************************************************
  // reporting
  // ****************************************************************
  // bit 0 and hardwired bits never report, whatever the detector drives
  wire aer_pkg::aer_word_t live_uncorr = UNCORR_EVENT_I & ~uncorr_mask_reg & `AER_SEV_WR_MASK
                                         & ~(32'h1 << `AER_SEV_UNUSED_BIT);
  wire logic next_fatal    = |(live_uncorr & uncorr_severity_reg);
  wire logic next_nonfatal = |(live_uncorr & ~uncorr_severity_reg);
  // a masked correctable event still lands in the status register; only its report is held back
  wire logic next_corr     = |(cor_evt & ~corr_mask_reg);

  // registering the reports costs one cycle of latency but keeps the pulses free of glitches
  // report pulses and read data come from flops; hot reset clears only the report pulses
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      fatal_q    <= 1'b0;
      nonfatal_q <= 1'b0;
      corr_q     <= 1'b0;
      rdata      <= 32'h00000000;
    end
    else if (CE_I)
    begin
      fatal_q    <= next_fatal && !HOT_RESET_I;
      nonfatal_q <= next_nonfatal && !HOT_RESET_I;
      corr_q     <= next_corr && !HOT_RESET_I;
      rdata      <= RD_I ? rd_mux : 32'h00000000;
    end
  end

  assign FATAL_REPORT_O    = fatal_q;
  assign NONFATAL_REPORT_O = nonfatal_q;
  assign CORR_REPORT_O     = corr_q;
  assign RDATA_O           = rdata;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_fatal;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && !HOT_RESET_I && |(UNCORR_EVENT_I & ~uncorr_mask_reg & uncorr_severity_reg & 32'h001f3030))
      |=> FATAL_REPORT_O;
  endproperty
  a_fatal: assert property (p_fatal) else $error("unmasked fatal event not reported");
  property p_masked;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && (UNCORR_EVENT_I & ~uncorr_mask_reg & 32'h001f3030) == 32'h0) |=> !FATAL_REPORT_O && !NONFATAL_REPORT_O;
  endproperty
  a_masked: assert property (p_masked) else $error("masked event was reported");
  property p_hardwired;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    uncorr_severity_reg[15:14] == 2'h0 && uncorr_severity_reg[11:6] == 6'h00 && uncorr_severity_reg[3:1] == 3'h0;
  endproperty
  a_hardwired: assert property (p_hardwired) else $error("read-only severity bit nonzero");
  property p_sev_write;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg == ($past(WDATA_I) & 32'h001f3031);
  endproperty
  a_sev_write: assert property (p_sev_write) else $error("severity write not stored");
  property p_cor_set;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && CORR_EVENT_I[`AER_COR_RX_ERR]) |=> corr_status_reg[`AER_COR_RX_ERR];
  endproperty
  a_cor_set: assert property (p_cor_set) else $error("receiver error not latched");
  property p_cor_clear;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (wr_cor && WDATA_I[`AER_COR_REPLAY_ROLL] && !CORR_EVENT_I[`AER_COR_REPLAY_ROLL])
      |=> !corr_status_reg[`AER_COR_REPLAY_ROLL];
  endproperty
  a_cor_clear: assert property (p_cor_clear) else $error("write one did not clear");
  property p_cor_hold;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (!wr_cor && corr_status_reg[`AER_COR_BAD_TLP]) |=> corr_status_reg[`AER_COR_BAD_TLP];
  endproperty
  a_cor_hold: assert property (p_cor_hold) else $error("sticky status lost");
  property p_reserved;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (corr_status_reg & ~32'h000031c1) == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bit set");
  property p_corr_masked;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && (CORR_EVENT_I & ~corr_mask_reg & 32'h000031c1) == 32'h0) |=> !CORR_REPORT_O;
  endproperty
  a_corr_masked: assert property (p_corr_masked) else $error("masked correctable reported");
  property p_hot;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && HOT_RESET_I && !wr_sev) |=> $stable(uncorr_severity_reg);
  endproperty
  a_hot: assert property (p_hot) else $error("hot reset disturbed sticky bits");
  // each writable severity bit takes exactly the bit written, one cycle later
  property p_sev_bit0;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg[`AER_SEV_UNUSED_BIT] == $past(WDATA_I[`AER_SEV_UNUSED_BIT]);
  endproperty
  a_sev_bit0: assert property (p_sev_bit0) else $error("unused severity bit not writable");
  property p_sev_bit4;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg[`AER_SEV_LINK_PROT] == $past(WDATA_I[`AER_SEV_LINK_PROT]);
  endproperty
  a_sev_bit4: assert property (p_sev_bit4) else $error("link protocol severity not writable");
  property p_sev_bit5;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg[`AER_SEV_SURPRISE] == $past(WDATA_I[`AER_SEV_SURPRISE]);
  endproperty
  a_sev_bit5: assert property (p_sev_bit5) else $error("surprise down severity not writable");
  property p_sev_bit12;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg[`AER_SEV_POISONED] == $past(WDATA_I[`AER_SEV_POISONED]);
  endproperty
  a_sev_bit12: assert property (p_sev_bit12) else $error("poisoned severity not writable");
  property p_sev_bit13;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg[`AER_SEV_FLOW_PROT] == $past(WDATA_I[`AER_SEV_FLOW_PROT]);
  endproperty
  a_sev_bit13: assert property (p_sev_bit13) else $error("flow control severity not writable");
  property p_sev_bit16;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg[`AER_SEV_UNEXP_COMPL] == $past(WDATA_I[`AER_SEV_UNEXP_COMPL]);
  endproperty
  a_sev_bit16: assert property (p_sev_bit16) else $error("unexpected completion severity not writable");
  property p_sev_bit17;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg[`AER_SEV_RX_OVERFLOW] == $past(WDATA_I[`AER_SEV_RX_OVERFLOW]);
  endproperty
  a_sev_bit17: assert property (p_sev_bit17) else $error("receiver overflow severity not writable");
  property p_sev_bit18;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg[`AER_SEV_BAD_FORMAT] == $past(WDATA_I[`AER_SEV_BAD_FORMAT]);
  endproperty
  a_sev_bit18: assert property (p_sev_bit18) else $error("bad format severity not writable");
  property p_sev_bit19;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg[`AER_SEV_ECRC] == $past(WDATA_I[`AER_SEV_ECRC]);
  endproperty
  a_sev_bit19: assert property (p_sev_bit19) else $error("ecrc severity not writable");
  property p_sev_bit20;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_sev |=> uncorr_severity_reg[`AER_SEV_UNSUP_REQ] == $past(WDATA_I[`AER_SEV_UNSUP_REQ]);
  endproperty
  a_sev_bit20: assert property (p_sev_bit20) else $error("unsupported request severity not writable");
  // completer abort can never be chosen, so its severity must stay zero
  property p_abort_zero;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    uncorr_severity_reg[`AER_SEV_COMPL_ABORT] == 1'b0;
  endproperty
  a_abort_zero: assert property (p_abort_zero) else $error("completer abort severity nonzero");
  // every correctable detector pulse latches its own status bit
  property p_set_bit6;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && CORR_EVENT_I[`AER_COR_BAD_TLP]) |=> corr_status_reg[`AER_COR_BAD_TLP];
  endproperty
  a_set_bit6: assert property (p_set_bit6) else $error("corrupt tlp not latched");
  property p_set_bit7;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && CORR_EVENT_I[`AER_COR_BAD_DLLP]) |=> corr_status_reg[`AER_COR_BAD_DLLP];
  endproperty
  a_set_bit7: assert property (p_set_bit7) else $error("corrupt dllp not latched");
  property p_set_bit8;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && CORR_EVENT_I[`AER_COR_REPLAY_ROLL]) |=> corr_status_reg[`AER_COR_REPLAY_ROLL];
  endproperty
  a_set_bit8: assert property (p_set_bit8) else $error("replay rollover not latched");
  property p_set_bit12;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && CORR_EVENT_I[`AER_COR_REPLAY_TMO]) |=> corr_status_reg[`AER_COR_REPLAY_TMO];
  endproperty
  a_set_bit12: assert property (p_set_bit12) else $error("replay timer expiry not latched");
  property p_set_bit13;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && CORR_EVENT_I[`AER_COR_ADVISORY]) |=> corr_status_reg[`AER_COR_ADVISORY];
  endproperty
  a_set_bit13: assert property (p_set_bit13) else $error("advisory nonfatal not latched");
  // writing one clears a status bit when no new event lands in the same cycle
  property p_clr_bit0;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (wr_cor && WDATA_I[`AER_COR_RX_ERR] && !CORR_EVENT_I[`AER_COR_RX_ERR])
      |=> !corr_status_reg[`AER_COR_RX_ERR];
  endproperty
  a_clr_bit0: assert property (p_clr_bit0) else $error("receiver error not cleared");
  property p_clr_bit6;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (wr_cor && WDATA_I[`AER_COR_BAD_TLP] && !CORR_EVENT_I[`AER_COR_BAD_TLP])
      |=> !corr_status_reg[`AER_COR_BAD_TLP];
  endproperty
  a_clr_bit6: assert property (p_clr_bit6) else $error("corrupt tlp not cleared");
  property p_clr_bit7;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (wr_cor && WDATA_I[`AER_COR_BAD_DLLP] && !CORR_EVENT_I[`AER_COR_BAD_DLLP])
      |=> !corr_status_reg[`AER_COR_BAD_DLLP];
  endproperty
  a_clr_bit7: assert property (p_clr_bit7) else $error("corrupt dllp not cleared");
  property p_clr_bit12;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (wr_cor && WDATA_I[`AER_COR_REPLAY_TMO] && !CORR_EVENT_I[`AER_COR_REPLAY_TMO])
      |=> !corr_status_reg[`AER_COR_REPLAY_TMO];
  endproperty
  a_clr_bit12: assert property (p_clr_bit12) else $error("replay timer expiry not cleared");
  property p_clr_bit13;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (wr_cor && WDATA_I[`AER_COR_ADVISORY] && !CORR_EVENT_I[`AER_COR_ADVISORY])
      |=> !corr_status_reg[`AER_COR_ADVISORY];
  endproperty
  a_clr_bit13: assert property (p_clr_bit13) else $error("advisory nonfatal not cleared");
  // reporting: the non-fatal path, the correctable path and the quiet cases
  property p_nonfatal;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && !HOT_RESET_I && |(UNCORR_EVENT_I & ~uncorr_mask_reg & ~uncorr_severity_reg & 32'h001f3030))
      |=> NONFATAL_REPORT_O;
  endproperty
  a_nonfatal: assert property (p_nonfatal) else $error("unmasked non-fatal event not reported");
  property p_corr_report;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && !HOT_RESET_I && |(CORR_EVENT_I & ~corr_mask_reg & `AER_COR_WR_MASK)) |=> CORR_REPORT_O;
  endproperty
  a_corr_report: assert property (p_corr_report) else $error("unmasked correctable not reported");
  property p_hot_quiet;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && HOT_RESET_I) |=> !FATAL_REPORT_O && !NONFATAL_REPORT_O && !CORR_REPORT_O;
  endproperty
  a_hot_quiet: assert property (p_hot_quiet) else $error("report pulse during hot reset");
  property p_unused_quiet;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && UNCORR_EVENT_I == 32'h00000001) |=> !FATAL_REPORT_O && !NONFATAL_REPORT_O;
  endproperty
  a_unused_quiet: assert property (p_unused_quiet) else $error("unused bit produced a report");
  // register port: holding, freezing and the one-cycle read answer
  property p_sev_hold;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    !wr_sev |=> $stable(uncorr_severity_reg);
  endproperty
  a_sev_hold: assert property (p_sev_hold) else $error("severity changed without a write");
  property p_ce_freeze;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    !CE_I |=> $stable(uncorr_severity_reg) && $stable(corr_status_reg) && $stable(RDATA_O);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while clock enable low");
  property p_rdata_idle;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && !RD_I) |=> RDATA_O == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero without a read");
  property p_read_sev;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && RD_I && ADDR_I == `AER_OFF_SEVERITY) |=> RDATA_O == $past(uncorr_severity_reg);
  endproperty
  a_read_sev: assert property (p_read_sev) else $error("severity read returned wrong word");
  property p_read_cor;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && RD_I && ADDR_I == `AER_OFF_CORR_STATUS) |=> RDATA_O == $past(corr_status_reg);
  endproperty
  a_read_cor: assert property (p_read_cor) else $error("status read returned wrong word");
  // the mask registers keep only their writable bits
  property p_umask_write;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_umask |=> uncorr_mask_reg == ($past(WDATA_I) & `AER_UMASK_WR_MASK);
  endproperty
  a_umask_write: assert property (p_umask_write) else $error("uncorrectable mask write not stored");
  property p_cmask_write;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_cmask |=> corr_mask_reg == ($past(WDATA_I) & `AER_COR_WR_MASK);
  endproperty
  a_cmask_write: assert property (p_cmask_write) else $error("correctable mask write not stored");
  c_fatal:    cover property (@(posedge CLK_I) FATAL_REPORT_O);
  c_nonfatal: cover property (@(posedge CLK_I) NONFATAL_REPORT_O);
  c_corr:     cover property (@(posedge CLK_I) CORR_REPORT_O);
  c_clear:    cover property (@(posedge CLK_I) wr_cor && |corr_status_reg);
  c_hot:      cover property (@(posedge CLK_I) CE_I && HOT_RESET_I && |CORR_EVENT_I);

endmodule : aer_regs

// >>> verification/aer_evt_model.sv
// ****************************************************************
// error detector model
// ****************************************************************
// each request reappears as a detector event a cycle later, held for as many cycles as the request
module aer_evt_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [31:0] req_uncorr_i,
  input  wire logic [31:0] req_corr_i,
  output logic [31:0]      uncorr_event_o,
  output logic [31:0]      corr_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // events simply follow the requests one cycle late, so a held request gives a held event
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      uncorr_event_o <= 32'h0;
      corr_event_o   <= 32'h0;
    end
    else
    begin
      uncorr_event_o <= req_uncorr_i;
      corr_event_o   <= req_corr_i;
    end
  end
endmodule : aer_evt_model

// >>> verification/pcie_aer_severity_status_bench.sv
`include "aer_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module pcie_aer_severity_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk, rst_n, hot, ce, wr, rd, fat, nft, cor;
  aer_pkg::aer_addr_t addr;
  aer_pkg::aer_word_t wdata, rdata, d;
  logic [31:0]        req_u, req_c, ev_u, ev_c;
  int                 err_count, num_checks, cycles;
  int                 ups[9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};
  int                 cps[6] = '{0, 6, 7, 8, 12, 13};
  aer_regs i_aer_regs (.CLK_I(clk), .RESET_N_I(rst_n), .HOT_RESET_I(hot), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .UNCORR_EVENT_I(ev_u), .CORR_EVENT_I(ev_c),
    .FATAL_REPORT_O(fat), .NONFATAL_REPORT_O(nft), .CORR_REPORT_O(cor));
  aer_evt_model i_aer_evt_model (.clk_i(clk), .rst_n_i(rst_n), .req_uncorr_i(req_u), .req_corr_i(req_c),
    .uncorr_event_o(ev_u), .corr_event_o(ev_c));
  // ****************************************************************
  // bus and event tasks, all entered and left at a rising edge
  // ****************************************************************
  task automatic wr_reg(input aer_pkg::aer_addr_t a, input aer_pkg::aer_word_t v);
  begin
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    // the idle edge keeps two writes in a row from driving wr twice in one step
    wr <= 1'b0;
    @(posedge clk);
  end
  endtask : wr_reg
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input aer_pkg::aer_addr_t a, output aer_pkg::aer_word_t v);
  begin
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  end
  endtask : rd_reg
  // model pulses after one edge, design reports one edge later
  task automatic fire(input logic [31:0] u, input logic [31:0] c, input logic [2:0] exp);
  begin
    req_u <= u;
    req_c <= c;
    @(posedge clk);
    req_u <= 32'h0;
    req_c <= 32'h0;
    @(posedge clk);
    #1 `CHK({fat, nft, cor}, exp)
    @(posedge clk);
  end
  endtask : fire
  task automatic results;
  begin
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask : results
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // a hang is cut short well past the two hundred or so cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      results();
    end
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    {rst_n, hot, wr, rd} <= 4'h0;
    ce <= 1'b1;
    {addr, wdata, req_u, req_c} <= '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(`AER_OFF_SEVERITY, d); `CHK(d, 32'h00062030)
    rd_reg(`AER_OFF_CORR_STATUS, d); `CHK(d, 32'h00000000)
    ce <= 1'b0;
    wr_reg(`AER_OFF_SEVERITY, 32'h0);
    ce <= 1'b1;
    rd_reg(`AER_OFF_SEVERITY, d); `CHK(d, 32'h00062030)
    wr_reg(`AER_OFF_SEVERITY, 32'hffffffff);
    rd_reg(`AER_OFF_SEVERITY, d); `CHK(d, 32'h001f3031)
    $display("test registers done");
    // each used severity bit chooses fatal when one and non-fatal when zero
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(`AER_OFF_SEVERITY, 32'h1 << ups[i]);
      fire(32'h1 << ups[i], 32'h0, 3'b100);
      wr_reg(`AER_OFF_SEVERITY, 32'h0);
      fire(32'h1 << ups[i], 32'h0, 3'b010);
    end
    wr_reg(`AER_OFF_SEVERITY, 32'h1);
    fire(32'h1, 32'h0, 3'b000);
    wr_reg(`AER_OFF_UNCORR_MASK, 32'h10);
    fire(32'h10, 32'h0, 3'b000);
    wr_reg(`AER_OFF_UNCORR_MASK, 32'h0);
    $display("test severity done");
    wr_reg(`AER_OFF_CORR_MASK, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      fire(32'h0, 32'h1 << cps[i], 3'b001);
      rd_reg(`AER_OFF_CORR_STATUS, d); `CHK(d, 32'h1 << cps[i])
      wr_reg(`AER_OFF_CORR_STATUS, 32'hffffffff);
      rd_reg(`AER_OFF_CORR_STATUS, d); `CHK(d, 32'h0)
    end
    wr_reg(`AER_OFF_CORR_MASK, 32'h1);
    fire(32'h0, 32'h1, 3'b000);
    rd_reg(`AER_OFF_CORR_STATUS, d); `CHK(d, 32'h1)
    $display("test correctable done");
    // a hot reset keeps sticky state; only the fundamental reset restores defaults
    wr_reg(`AER_OFF_SEVERITY, 32'h1000);
    hot <= 1'b1;
    fire(32'h0, 32'h40, 3'b000);
    hot <= 1'b0;
    rd_reg(`AER_OFF_SEVERITY, d); `CHK(d, 32'h1000)
    rd_reg(`AER_OFF_CORR_STATUS, d); `CHK(d, 32'h41)
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(`AER_OFF_SEVERITY, d); `CHK(d, 32'h00062030)
    rd_reg(`AER_OFF_CORR_STATUS, d); `CHK(d, 32'h0)
    $display("test sticky done");
    results();
  end
endmodule : pcie_aer_severity_status_bench
